// >>> verilog/wdt_pkg.sv
// Package of constants, types and register map for the watchdog block.
// Summary of operation
// - Unserviced enabled watchdog forces a full system reset at timeout.
// - Counter chain counts divided oscillator ticks at the chosen rate.
// - Writing zero to bit 0 of the service address restarts the countdown.
// - Counter chain is held cleared during reset and during stop mode.
// - Stop flag set by its reset; power-on, external, watchdog clear it.
// - Address flag set by its reset; power-on, external, watchdog clear it.
// - Watchdog flag set by timeout; cleared by power-on, external, address.
// - Resets only with the factory option set; software cannot turn it off.
// - Rate bits load only on the first control register write after reset.
// - Rate bits never written leave the one-second default, encoding zero.
// - A write that loads the rate bits clears the counter chain.
// - Bit set or clear is a full write; as first write it locks defaults.
// - Rates 00 to 11 give 1, 2, 4 and 8 seconds at 32.768 kHz.
// - In wait mode the watchdog keeps counting and can still time out.
// - Stop mode holds the watchdog counter cleared; counting restarts from zero.
// - Control register holds rate, inhibit, irq level and cause flags.
package wdt_pkg;

   // =========================================================================
   // Register map.
   localparam logic [15:0] ADDR_CTRL_STATUS = 16'h0013;
   localparam logic [15:0] ADDR_IRQ_STATUS  = 16'h0014;
   localparam logic [15:0] ADDR_IRQ_CLEAR   = 16'h0015;
   localparam logic [15:0] ADDR_IRQ_ENABLE  = 16'h0016;
   localparam logic [15:0] ADDR_SERVICE     = 16'h1FF0;

   // =========================================================================
   // Control and status register fields.
   localparam int unsigned BIT_RATE_LOW     = 0;
   localparam int unsigned BIT_RATE_HIGH    = 1;
   localparam int unsigned BIT_WDT_FLAG     = 2;
   localparam int unsigned BIT_ILADDR_FLAG  = 3;
   localparam int unsigned BIT_STOP_FLAG    = 4;
   localparam int unsigned BIT_IRQ_LEVEL    = 5;
   localparam int unsigned BIT_STOP_INHIBIT = 6;
   localparam int unsigned BIT_SERVICE      = 0;
   localparam logic [1:0]  RATE_RESET       = 2'h0;
   localparam logic        IRQ_LEVEL_RESET  = 1'h0;
   localparam logic        STOP_INH_RESET   = 1'h0;

   // =========================================================================
   // Interrupt status bits.
   localparam int unsigned IRQ_BITS         = 3;
   localparam int unsigned IRQ_SERVICED     = 0;
   localparam int unsigned IRQ_RATE_LOCKED  = 1;
   localparam int unsigned IRQ_HALF_WAY     = 2;
   localparam logic [2:0]  IRQ_EN_RESET     = 3'h0;

   // =========================================================================
   // Timing.
   localparam int unsigned SYS_CLK_HZ       = 20000000;
   localparam int unsigned OSC_HZ           = 32768;
   localparam int unsigned MIN_TIMEOUT_S    = 1;
   localparam int unsigned BASE_TICKS       = OSC_HZ * MIN_TIMEOUT_S;
   localparam int unsigned RST_PULSE_NS     = 200;
   localparam int unsigned RST_PULSE_CYC    =
      (RST_PULSE_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;

   // =========================================================================
   // Types.
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } wdt_bus_req_s;

   typedef struct packed {
      logic ext;
      logic iladdr;
      logic stop;
   } wdt_rst_cause_s;

   typedef enum logic [0:0] {
      WDT_RUN,
      WDT_RESETTING
   } wdt_state_e;

endpackage : wdt_pkg

// >>> verilog/wdt_top.sv
// Watchdog timer with write-once rate select and reset-cause flags.
//
// The address-and-strobe port was chosen for this implementation.
module wdt_top #(
   parameter int unsigned BASE_TICKS = wdt_pkg::BASE_TICKS,
   parameter int unsigned RST_CYCLES = wdt_pkg::RST_PULSE_CYC
) (
   // Clock, reset and clock enable.
   input  wire logic                   sys_clk_in,
   input  wire logic                   rst_n_in,
   input  wire logic                   ce_in,
   // Register port.
   input  wire wdt_pkg::wdt_bus_req_s  bus_in,
   output logic [7:0]                  rdata_out,
   // Oscillator tick and operating modes.
   input  wire logic                   osc_tick_in,
   input  wire logic                   wait_mode_in,
   input  wire logic                   stop_mode_in,
   input  wire logic                   option_enable_in,
   // Reset causes from the rest of the system.
   input  wire wdt_pkg::wdt_rst_cause_s cause_in,
   // Outputs.
   output logic                        wdt_reset_out,
   output logic                        irq_level_sel_out,
   output logic                        stop_inhibit_out,
   output logic                        irq_out
);

   localparam int unsigned CW = $clog2(BASE_TICKS * 8) + 1;
   localparam int unsigned RW = $clog2(RST_CYCLES + 1) + 1;

   // =========================================================================
   // Parameter checks.
   if (BASE_TICKS < 2 || RST_CYCLES < 1
       || BASE_TICKS > 32'h0FFFFFFF) begin : g_bad_param
      $error("wdt_top: unsupported parameter values");
   end

   // =========================================================================
   // State.
   typedef struct packed {
      wdt_pkg::wdt_state_e       state;
      logic [CW-1:0]             count;
      logic [1:0]                rate;
      logic                      locked;
      logic                      flag_wdt;
      logic                      flag_iladdr;
      logic                      flag_stop;
      logic                      irq_level;
      logic                      stop_inh;
      logic [RW-1:0]             rst_cnt;
      logic [wdt_pkg::IRQ_BITS-1:0] irq_stat;
      logic [wdt_pkg::IRQ_BITS-1:0] irq_en;
      logic [7:0]                rdata;
   } wdt_state_s;

   wdt_state_s st;
   wdt_state_s next_st;

   logic [CW-1:0] limit;
   logic          wr_ctrl;
   logic          wr_service;
   logic          timeout;
   logic          half_way;
   logic [wdt_pkg::IRQ_BITS-1:0] irq_set;
   logic [wdt_pkg::IRQ_BITS-1:0] irq_clr;

   // =========================================================================
   // Decode and timeout detection.
   always_comb begin
      limit = CW'(BASE_TICKS) << st.rate;
      wr_ctrl = bus_in.wr && bus_in.addr == wdt_pkg::ADDR_CTRL_STATUS;
      wr_service = bus_in.wr && bus_in.addr == wdt_pkg::ADDR_SERVICE
         && !bus_in.wdata[wdt_pkg::BIT_SERVICE];
      timeout = osc_tick_in && !stop_mode_in
         && st.count == limit - CW'(1) && option_enable_in;
      half_way = osc_tick_in && !stop_mode_in
         && st.count == (limit >> 1);
      irq_set = '0;
      irq_set[wdt_pkg::IRQ_SERVICED] = wr_service;
      irq_set[wdt_pkg::IRQ_RATE_LOCKED] = wr_ctrl && !st.locked;
      irq_set[wdt_pkg::IRQ_HALF_WAY] = half_way;
      irq_clr = '0;
      if (bus_in.wr && bus_in.addr == wdt_pkg::ADDR_IRQ_CLEAR) begin
         irq_clr = bus_in.wdata[wdt_pkg::IRQ_BITS-1:0];
      end
   end

   // =========================================================================
   // Next-state logic.
   always_comb begin
      next_st = st;
      next_st.rdata = 8'h00;

      // Interrupt status: a new event wins over a clear in the same cycle.
      next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;

      case (st.state)
         wdt_pkg::WDT_RUN: begin
            if (stop_mode_in) begin
               next_st.count = '0;
            end else if (wr_service) begin
               next_st.count = '0;
            end else if (wr_ctrl && !st.locked) begin
               next_st.count = '0;
            end else if (osc_tick_in) begin
               // Counting continues in wait mode.
               if (st.count < limit - CW'(1)) begin
                  next_st.count = st.count + CW'(1);
               end
            end

            if (wr_ctrl) begin
               if (!st.locked) begin
                  // Any first write, including a bit set or clear, locks.
                  next_st.rate = {bus_in.wdata[wdt_pkg::BIT_RATE_HIGH],
                                  bus_in.wdata[wdt_pkg::BIT_RATE_LOW]};
                  next_st.locked = 1'b1;
               end
               next_st.irq_level = bus_in.wdata[wdt_pkg::BIT_IRQ_LEVEL];
               next_st.stop_inh = bus_in.wdata[wdt_pkg::BIT_STOP_INHIBIT];
            end

            if (bus_in.wr && bus_in.addr == wdt_pkg::ADDR_IRQ_ENABLE) begin
               next_st.irq_en = bus_in.wdata[wdt_pkg::IRQ_BITS-1:0];
            end

            if (timeout) begin
               next_st.state = wdt_pkg::WDT_RESETTING;
               next_st.rst_cnt = RW'(RST_CYCLES);
               next_st.count = '0;
            end
         end
         wdt_pkg::WDT_RESETTING: begin
            next_st.count = '0;
            if (st.rst_cnt > RW'(1)) begin
               next_st.rst_cnt = st.rst_cnt - RW'(1);
            end else begin
               next_st.state = wdt_pkg::WDT_RUN;
               next_st.rst_cnt = '0;
               next_st.flag_wdt = 1'b1;
               next_st.flag_iladdr = 1'b0;
               next_st.flag_stop = 1'b0;
               next_st.rate = wdt_pkg::RATE_RESET;
               next_st.locked = 1'b0;
               next_st.irq_level = wdt_pkg::IRQ_LEVEL_RESET;
               next_st.stop_inh = wdt_pkg::STOP_INH_RESET;
               next_st.irq_stat = '0;
               next_st.irq_en = wdt_pkg::IRQ_EN_RESET;
            end
         end
         default: begin
            next_st.state = wdt_pkg::WDT_RUN;
         end
      endcase

      // Other system resets reinitialise control and update the flags.
      if (cause_in.ext || cause_in.iladdr || cause_in.stop) begin
         next_st.state = wdt_pkg::WDT_RUN;
         next_st.count = '0;
         next_st.rst_cnt = '0;
         next_st.rate = wdt_pkg::RATE_RESET;
         next_st.locked = 1'b0;
         next_st.irq_level = wdt_pkg::IRQ_LEVEL_RESET;
         next_st.stop_inh = wdt_pkg::STOP_INH_RESET;
         next_st.irq_stat = '0;
         next_st.irq_en = wdt_pkg::IRQ_EN_RESET;
         if (cause_in.ext) begin
            next_st.flag_wdt = 1'b0;
            next_st.flag_iladdr = 1'b0;
            next_st.flag_stop = 1'b0;
         end else if (cause_in.iladdr) begin
            next_st.flag_iladdr = 1'b1;
            next_st.flag_wdt = 1'b0;
         end else begin
            next_st.flag_stop = 1'b1;
         end
      end

      // Read data, valid in the cycle after the read strobe.
      if (bus_in.rd) begin
         if (bus_in.addr == wdt_pkg::ADDR_CTRL_STATUS) begin
            next_st.rdata[wdt_pkg::BIT_RATE_LOW] = st.rate[0];
            next_st.rdata[wdt_pkg::BIT_RATE_HIGH] = st.rate[1];
            next_st.rdata[wdt_pkg::BIT_WDT_FLAG] = st.flag_wdt;
            next_st.rdata[wdt_pkg::BIT_ILADDR_FLAG] = st.flag_iladdr;
            next_st.rdata[wdt_pkg::BIT_STOP_FLAG] = st.flag_stop;
            next_st.rdata[wdt_pkg::BIT_IRQ_LEVEL] = st.irq_level;
            next_st.rdata[wdt_pkg::BIT_STOP_INHIBIT] = st.stop_inh;
         end else if (bus_in.addr == wdt_pkg::ADDR_IRQ_STATUS) begin
            next_st.rdata[wdt_pkg::IRQ_BITS-1:0] = st.irq_stat;
         end else if (bus_in.addr == wdt_pkg::ADDR_IRQ_ENABLE) begin
            next_st.rdata[wdt_pkg::IRQ_BITS-1:0] = st.irq_en;
         end else begin
            next_st.rdata = 8'h00;
         end
      end
   end

   // =========================================================================
   // State register.
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         // Power-on reset clears all cause flags and the chain.
         st.state       <= wdt_pkg::WDT_RUN;
         st.count       <= '0;
         st.rate        <= wdt_pkg::RATE_RESET;
         st.locked      <= 1'b0;
         st.flag_wdt    <= 1'b0;
         st.flag_iladdr <= 1'b0;
         st.flag_stop   <= 1'b0;
         st.irq_level   <= wdt_pkg::IRQ_LEVEL_RESET;
         st.stop_inh    <= wdt_pkg::STOP_INH_RESET;
         st.rst_cnt     <= '0;
         st.irq_stat    <= '0;
         st.irq_en      <= wdt_pkg::IRQ_EN_RESET;
         st.rdata       <= 8'h00;
      end else if (ce_in) begin
         st <= next_st;
      end
   end

   // =========================================================================
   // Outputs.
   assign rdata_out = st.rdata;
   assign wdt_reset_out = st.state == wdt_pkg::WDT_RESETTING;
   assign irq_level_sel_out = st.irq_level;
   assign stop_inhibit_out = st.stop_inh;
   assign irq_out = |(st.irq_stat & st.irq_en);

endmodule : wdt_top

// >>> test/wdt_top_props.sv
// Port-level concurrent checks for the watchdog block.
module wdt_props #(
   parameter int unsigned BASE_TICKS = 4,
   parameter int unsigned RST_CYCLES = 4
) (
   // Clock, reset and inputs.
   input wire logic                    sys_clk_in,
   input wire logic                    rst_n_in,
   input wire wdt_pkg::wdt_bus_req_s   bus_in,
   input wire logic                    osc_tick_in,
   input wire logic                    stop_mode_in,
   input wire logic                    option_enable_in,
   input wire wdt_pkg::wdt_rst_cause_s cause_in,
   // Outputs.
   input wire logic [7:0]              rdata_out,
   input wire logic                    wdt_reset_out,
   input wire logic                    irq_level_sel_out,
   input wire logic                    stop_inhibit_out,
   input wire logic                    irq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================================
   // Helper counters.
   logic [15:0] ticks;
   logic [7:0]  hi_cnt;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ticks  <= 16'h0000;
         hi_cnt <= 8'h00;
      end else begin
         hi_cnt <= wdt_reset_out ? hi_cnt + 8'h01 : 8'h00;
         if (stop_mode_in || wdt_reset_out || (bus_in.wr && !bus_in.wdata[0]
             && bus_in.addr == wdt_pkg::ADDR_SERVICE)) begin
            ticks <= 16'h0000;
         end else if (osc_tick_in) begin
            ticks <= ticks + 16'h0001;
         end
      end
   end
   // ==========================================================================
   // Assertions.
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   a_rdata_idle: assert property (
      !$past(bus_in.rd) |-> rdata_out == 8'h00) else $error("rdata not idle");
   a_ctrl_bit7: assert property (
      $past(bus_in.rd) && $past(bus_in.addr) == wdt_pkg::ADDR_CTRL_STATUS
      |-> !rdata_out[7]) else $error("control bit 7 not zero");
   a_timeout_cause: assert property (
      $rose(wdt_reset_out) |-> $past(osc_tick_in) && $past(option_enable_in)
      && !$past(stop_mode_in)) else $error("reset without its cause");
   a_min_ticks: assert property (
      $rose(wdt_reset_out) |-> ticks >= BASE_TICKS)
      else $error("reset before the timeout");
   a_pulse_len: assert property (
      $fell(wdt_reset_out) |-> hi_cnt == RST_CYCLES)
      else $error("reset pulse length wrong");
   a_irq_cleared: assert property (
      $fell(wdt_reset_out) |-> !irq_out) else $error("irq after reset");
   a_ctrl_reinit: assert property (
      $fell(wdt_reset_out) |-> !irq_level_sel_out && !stop_inhibit_out)
      else $error("control not cleared by timeout");
   a_ext_reinit: assert property (
      cause_in.ext |=> !irq_level_sel_out && !stop_inhibit_out)
      else $error("control not cleared by external reset");
endmodule : wdt_props

bind wdt_top wdt_props #(.BASE_TICKS(BASE_TICKS), .RST_CYCLES(RST_CYCLES))
   u_props (.sys_clk_in, .rst_n_in, .bus_in, .osc_tick_in, .stop_mode_in,
   .option_enable_in, .cause_in, .rdata_out, .wdt_reset_out,
   .irq_level_sel_out, .stop_inhibit_out, .irq_out);

// >>> test/wdt_top_tb.sv
// Self-checking testbench for the watchdog block.
module wdt_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================================
   // Signals and design.
   logic                    sys_clk_in = 1'b0;
   logic                    rst_n_in = 1'b0;
   logic                    osc_tick_in = 1'b0;
   logic                    wait_mode_in = 1'b0;
   logic                    stop_mode_in = 1'b0;
   logic                    option_enable_in = 1'b1;
   logic                    ce_in = 1'b1;
   wdt_pkg::wdt_bus_req_s   bus_in = '0;
   wdt_pkg::wdt_rst_cause_s cause_in = '0;
   logic [7:0]              rdata_out;
   logic                    wdt_reset_out;
   logic                    irq_level_sel_out;
   logic                    stop_inhibit_out;
   logic                    irq_out;
   int                      n_fail = 0;
   int                      n_checks = 0;
   always #25 sys_clk_in = ~sys_clk_in;
   wdt_top #(.BASE_TICKS(4), .RST_CYCLES(4)) dut (.sys_clk_in, .rst_n_in,
      .ce_in, .bus_in, .rdata_out, .osc_tick_in, .wait_mode_in,
      .stop_mode_in, .option_enable_in, .cause_in, .wdt_reset_out,
      .irq_level_sel_out, .stop_inhibit_out, .irq_out);
   // ==========================================================================
   // Tasks.
   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      bus_in.addr  <= a;
      bus_in.wdata <= d;
      bus_in.wr    <= 1'b1;
      @(posedge sys_clk_in);
      bus_in.wr    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge sys_clk_in);
      bus_in.addr <= a;
      bus_in.rd   <= 1'b1;
      @(posedge sys_clk_in);
      bus_in.rd   <= 1'b0;
      #1 chk($sformatf("read %h", a), rdata_out, exp);
   endtask : rd
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge sys_clk_in);
         osc_tick_in <= 1'b1;
         @(posedge sys_clk_in);
         osc_tick_in <= 1'b0;
      end
   endtask : tick
   task automatic bite(input logic exp);
      repeat (2) @(posedge sys_clk_in);
      #1 chk("wdt_reset_out", wdt_reset_out, exp);
      if (exp) begin
         repeat (2) @(posedge sys_clk_in);
         #1 chk("wdt_reset_out end", wdt_reset_out, 1'b0);
      end
      @(posedge sys_clk_in);
   endtask : bite
   task automatic pulse(input logic [2:0] c);
      @(posedge sys_clk_in);
      cause_in <= c;
      @(posedge sys_clk_in);
      cause_in <= '0;
   endtask : pulse
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   // ==========================================================================
   // Tests.
   initial begin
      #1000000;
      n_fail++;
      finish_test();
   end
   initial begin
      repeat (3) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      rd(wdt_pkg::ADDR_CTRL_STATUS, 8'h00);
      rd(16'h0020, 8'h00);
      wr(wdt_pkg::ADDR_IRQ_ENABLE, 8'h01);
      rd(wdt_pkg::ADDR_IRQ_ENABLE, 8'h01);
      wr(wdt_pkg::ADDR_SERVICE, 8'h00);
      #1 chk("irq_out", irq_out, 1'b1);
      wr(wdt_pkg::ADDR_IRQ_CLEAR, 8'h07);
      #1 chk("irq_out", irq_out, 1'b0);
      wr(wdt_pkg::ADDR_IRQ_ENABLE, 8'h00);
      wr(wdt_pkg::ADDR_SERVICE, 8'h01);
      rd(wdt_pkg::ADDR_IRQ_STATUS, 8'h00);
      wr(wdt_pkg::ADDR_SERVICE, 8'h00);
      #1 chk("irq_out", irq_out, 1'b0);
      wr(wdt_pkg::ADDR_CTRL_STATUS, 8'h60);
      rd(wdt_pkg::ADDR_CTRL_STATUS, 8'h60);
      chk("stop_inhibit_out", stop_inhibit_out, 1'b1);
      chk("irq_level_sel_out", irq_level_sel_out, 1'b1);
      wr(wdt_pkg::ADDR_CTRL_STATUS, 8'h9F);
      rd(wdt_pkg::ADDR_CTRL_STATUS, 8'h00);
      rd(wdt_pkg::ADDR_IRQ_STATUS, 8'h03);
      pulse(3'h4);
      for (int r = 0; r < 4; r++) begin
         wr(wdt_pkg::ADDR_SERVICE, 8'h00);
         tick(2);
         wr(wdt_pkg::ADDR_CTRL_STATUS, 8'(r));
         tick((4 << r) - 1);
         bite(1'b0);
         tick(1);
         bite(1'b1);
         rd(wdt_pkg::ADDR_CTRL_STATUS, 8'h04);
      end
      pulse(3'h1);
      rd(wdt_pkg::ADDR_CTRL_STATUS, 8'h14);
      pulse(3'h2);
      rd(wdt_pkg::ADDR_CTRL_STATUS, 8'h18);
      wr(wdt_pkg::ADDR_SERVICE, 8'h00);
      tick(4);
      bite(1'b1);
      rd(wdt_pkg::ADDR_CTRL_STATUS, 8'h04);
      pulse(3'h4);
      rd(wdt_pkg::ADDR_CTRL_STATUS, 8'h00);
      wr(wdt_pkg::ADDR_SERVICE, 8'h00);
      tick(3);
      @(posedge sys_clk_in);
      stop_mode_in <= 1'b1;
      tick(6);
      bite(1'b0);
      stop_mode_in <= 1'b0;
      tick(3);
      bite(1'b0);
      tick(1);
      bite(1'b1);
      wr(wdt_pkg::ADDR_SERVICE, 8'h00);
      stop_mode_in <= 1'b1;
      tick(2);
      stop_mode_in <= 1'b0;
      wait_mode_in <= 1'b1;
      tick(3);
      wait_mode_in <= 1'b0;
      wr(wdt_pkg::ADDR_SERVICE, 8'h00);
      wait_mode_in <= 1'b1;
      tick(3);
      bite(1'b0);
      tick(1);
      bite(1'b1);
      option_enable_in <= 1'b0;
      wr(wdt_pkg::ADDR_SERVICE, 8'h00);
      tick(10);
      bite(1'b0);
      option_enable_in <= 1'b1;
      ce_in <= 1'b0;
      tick(2);
      bite(1'b0);
      ce_in <= 1'b1;
      tick(1);
      bite(1'b1);
      rst_n_in <= 1'b0;
      @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      rd(wdt_pkg::ADDR_CTRL_STATUS, 8'h00);
      finish_test();
   end
endmodule : wdt_top_tb
